//--- logic/vcd_decoder.sv
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module vcd_decoder #(
   parameter int FRAME_CYCLES_P = vcd_pkg::FRAME_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output vcd_pkg::vcd_rot_evt_t rot_evt
);
   import vcd_pkg::*;

   function automatic logic [15:0] le16(input logic [7:0] lo, input logic [7:0] hi);
      le16 = {hi, lo}; // [R2]
   endfunction : le16

   function automatic logic [4:0] param_len(input logic [7:0] op);
      case (op)
         OP_SET_VIEWPORT: param_len = LEN_VIEWPORT;
         OP_SET_WINDOW: param_len = LEN_WINDOW;
         OP_ROTATE_VIEW_X, OP_ROTATE_VIEW_Y, OP_ROTATE_VIEW_Z: param_len = LEN_ANGLE;
         OP_VIEW_REF_POINT: param_len = LEN_REF_POINT;
         OP_DELAY: param_len = LEN_DELAY;
         OP_CROSSHAIR_ENABLE: param_len = LEN_XH_FLAG;
         OP_CROSSHAIR_POSITION: param_len = LEN_XH_POS;
         default: param_len = 5'h00;
      endcase
   endfunction : param_len

   // window extent must not overflow and must not be empty
   function automatic logic [1:0] span_check(input logic [31:0] a, input logic [31:0] b);
      logic [32:0] d;
      d = {b[31], b} - {a[31], a};
      span_check = {d[32] != d[31], d == 33'h0};
   endfunction : span_check

   vcd_state_t state_q;
   logic [7:0] opcode_q, awaddr_q, byte_in;
   logic [4:0] need_q, cnt_q, need_eff;
   logic [7:0] pbuf_q [0:15];
   logic [31:0] tick_q, wdata_q, rdata_q;
   vcd_viewport_t viewport_q, vp_new;
   logic [15:0] frames_left_q, xh_size_x_q, xh_size_y_q, xh_pos_x_q, xh_pos_y_q;
   logic [15:0] p0, p1, p2, p3;
   logic xh_on_q, xh_clip_vp_q, warn_q, range_q, ovf_q, bad_op_q;
   logic [31:0] ref_q [0:2];
   logic [31:0] win_q [0:3];
   logic [15:0] rot_q [0:2];
   logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q, chk_x, chk_y;
   vcd_rot_evt_t rot_evt_q;
   logic can_take, wr_fire, wr_known, byte_push, exec;
   logic warn_set, range_set, ovf_set, bad_op_set;

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign rot_evt = rot_evt_q;

   // bytes are only taken while the decoder is not executing or waiting
   assign can_take = (state_q == VCD_IDLE) || (state_q == VCD_PARAM); // [R10]
   assign wr_known = (awaddr_q == ADDR_CMD) || (awaddr_q == ADDR_STATUS);
   // a command byte write is held off, not dropped, while the decoder stalls
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q &&
                    ((awaddr_q != ADDR_CMD) || can_take);
   assign byte_push = wr_fire && (awaddr_q == ADDR_CMD) && wstrb_q[0];
   assign byte_in = wdata_q[7:0];
   assign exec = (state_q == VCD_EXEC);

   assign p0 = le16(pbuf_q[0], pbuf_q[1]);
   assign p1 = le16(pbuf_q[2], pbuf_q[3]);
   assign p2 = le16(pbuf_q[4], pbuf_q[5]);
   assign p3 = le16(pbuf_q[6], pbuf_q[7]);
   assign chk_x = span_check({pbuf_q[3], pbuf_q[2], pbuf_q[1], pbuf_q[0]},
                             {pbuf_q[7], pbuf_q[6], pbuf_q[5], pbuf_q[4]});
   assign chk_y = span_check({pbuf_q[11], pbuf_q[10], pbuf_q[9], pbuf_q[8]},
                             {pbuf_q[15], pbuf_q[14], pbuf_q[13], pbuf_q[12]});

   // crosshair flag 1 or 3 extends the command by two sizes
   always_comb begin
      need_eff = need_q;
      if (opcode_q == OP_CROSSHAIR_ENABLE && cnt_q == 5'h00 &&
          (byte_in == XH_FLAG_SCREEN || byte_in == XH_FLAG_VIEWPORT)) begin
         need_eff = LEN_XH_FULL; // [R14]
      end
   end

   // viewport: out-of-screen warns, unordered pair warns and swaps
   always_comb begin
      vp_new = '{p0, p1, p2, p3}; // [R1] [R4]
      warn_set = 1'b0;
      if (exec && opcode_q == OP_SET_VIEWPORT) begin
         if (p0 > SCREEN_X_MAX || p1 > SCREEN_X_MAX ||
             p2 > SCREEN_Y_MAX || p3 > SCREEN_Y_MAX) begin
            warn_set = 1'b1; // [R6]
         end
         if (p0 >= p1) begin
            warn_set = 1'b1; // [R5]
            {vp_new.x1, vp_new.x2} = {p1, p0};
         end
         if (p2 >= p3) begin
            warn_set = 1'b1; // [R5]
            {vp_new.y1, vp_new.y2} = {p3, p2};
         end
      end
   end

   always_comb begin
      range_set = 1'b0;
      ovf_set = 1'b0;
      if (exec) begin
         if (opcode_q == OP_SET_WINDOW) begin
            ovf_set = chk_x[1] || chk_y[1]; // [R13]
            range_set = chk_x[0] || chk_y[0]; // [R13]
         end
         if (opcode_q == OP_CROSSHAIR_ENABLE) begin
            if (pbuf_q[0] == XH_FLAG_SCREEN || pbuf_q[0] == XH_FLAG_VIEWPORT) begin
               range_set = le16(pbuf_q[1], pbuf_q[2]) > XH_SIZE_MAX ||
                           le16(pbuf_q[3], pbuf_q[4]) > XH_SIZE_MAX; // [R19]
            end else if (pbuf_q[0] != XH_FLAG_OFF) begin
               range_set = 1'b1; // [R19]
            end
         end
         if (opcode_q == OP_CROSSHAIR_POSITION) begin
            range_set = p0 > SCREEN_X_MAX || p1 > SCREEN_Y_MAX; // [R19]
         end
      end
   end

   assign bad_op_set = byte_push && state_q == VCD_IDLE && param_len(byte_in) == 5'h00;

   // command sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= VCD_IDLE;
         opcode_q <= 8'h00;
         need_q <= 5'h00;
         cnt_q <= 5'h00;
      end else begin
         case (state_q)
            VCD_IDLE: begin
               if (byte_push && param_len(byte_in) != 5'h00) begin
                  opcode_q <= byte_in;
                  need_q <= param_len(byte_in); // [R20]
                  cnt_q <= 5'h00;
                  state_q <= VCD_PARAM;
               end
            end
            VCD_PARAM: begin
               if (byte_push) begin
                  cnt_q <= cnt_q + 5'h01;
                  need_q <= need_eff;
                  if (cnt_q + 5'h01 == need_eff) begin
                     state_q <= VCD_EXEC; // [R20]
                  end
               end
            end
            VCD_EXEC: begin
               state_q <= (opcode_q == OP_DELAY && p0 != 16'h0000) ? VCD_DELAY // [R10]
                                                                   : VCD_IDLE;
            end
            default: begin
               if (frames_left_q == 16'h0001 && tick_q == 32'h0) begin
                  state_q <= VCD_IDLE; // [R10]
               end
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (state_q == VCD_PARAM && byte_push) begin
         pbuf_q[cnt_q[3:0]] <= byte_in;
      end
   end

   // frame timer, each frame one sixtieth of a second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frames_left_q <= 16'h0000;
         tick_q <= 32'h0;
      end else if (exec && opcode_q == OP_DELAY) begin
         frames_left_q <= p0; // [R9]
         tick_q <= 32'(FRAME_CYCLES_P - 1);
      end else if (state_q == VCD_DELAY) begin
         if (tick_q == 32'h0) begin
            tick_q <= 32'(FRAME_CYCLES_P - 1); // [R10]
            frames_left_q <= frames_left_q - 16'h0001;
         end else begin
            tick_q <= tick_q - 32'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         viewport_q <= VIEWPORT_RESET; // [R3]
      end else if (exec && opcode_q == OP_SET_VIEWPORT) begin
         viewport_q <= vp_new; // [R5]
      end
   end

   // window is kept raw; the mapping stage reads it with viewport_q
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         win_q <= '{4{32'h0}};
      end else if (exec && opcode_q == OP_SET_WINDOW && !ovf_set && !range_set) begin
         for (int i = 0; i < 4; i++) begin
            win_q[i] <= {pbuf_q[4*i+3], pbuf_q[4*i+2], pbuf_q[4*i+1], pbuf_q[4*i]}; // [R11] [R12]
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_q <= '{3{32'h0}};
      end else if (exec && opcode_q == OP_VIEW_REF_POINT) begin
         for (int i = 0; i < 3; i++) begin
            ref_q[i] <= {pbuf_q[4*i+3], pbuf_q[4*i+2], pbuf_q[4*i+1], pbuf_q[4*i]}; // [R8]
         end
      end
   end

   // rotation: angle kept per axis and announced to the matrix unit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rot_q <= '{3{16'h0000}};
         rot_evt_q <= '0;
      end else begin
         rot_evt_q.valid <= 1'b0;
         if (exec && (opcode_q == OP_ROTATE_VIEW_X || opcode_q == OP_ROTATE_VIEW_Y ||
                      opcode_q == OP_ROTATE_VIEW_Z)) begin
            rot_q[2'(opcode_q - OP_ROTATE_VIEW_X)] <= p0; // [R7]
            rot_evt_q.valid <= 1'b1;
            rot_evt_q.axis <= 2'(opcode_q - OP_ROTATE_VIEW_X); // [R7]
            rot_evt_q.angle <= p0;
         end
      end
   end

   // crosshair: complement drawing done by the raster unit from these
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xh_on_q <= 1'b0;
         xh_clip_vp_q <= 1'b0;
         xh_size_x_q <= 16'h0000;
         xh_size_y_q <= 16'h0000;
         xh_pos_x_q <= 16'h0000;
         xh_pos_y_q <= 16'h0000;
      end else if (exec && !range_set) begin
         if (opcode_q == OP_CROSSHAIR_ENABLE) begin
            if (pbuf_q[0] == XH_FLAG_OFF) begin
               xh_on_q <= 1'b0; // [R17]
            end else begin
               xh_on_q <= 1'b1; // [R16]
               xh_clip_vp_q <= (pbuf_q[0] == XH_FLAG_VIEWPORT); // [R15]
               xh_size_x_q <= le16(pbuf_q[1], pbuf_q[2]); // [R14]
               xh_size_y_q <= le16(pbuf_q[3], pbuf_q[4]);
            end
         end
         if (opcode_q == OP_CROSSHAIR_POSITION) begin
            xh_pos_x_q <= p0; // [R18]
            xh_pos_y_q <= p1;
         end
      end
   end

   // sticky flags, write one to clear; a new event beats the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warn_q <= 1'b0;
         range_q <= 1'b0;
         ovf_q <= 1'b0;
         bad_op_q <= 1'b0;
      end else begin
         if (wr_fire && awaddr_q == ADDR_STATUS && wstrb_q[0]) begin
            warn_q <= warn_set || (warn_q && !wdata_q[ST_WARN]);
            range_q <= range_set || (range_q && !wdata_q[ST_RANGE]);
            ovf_q <= ovf_set || (ovf_q && !wdata_q[ST_OVERFLOW]);
            bad_op_q <= bad_op_set || (bad_op_q && !wdata_q[ST_BAD_OP]);
         end else begin
            warn_q <= warn_q || warn_set; // [R5] [R6]
            range_q <= range_q || range_set; // [R19]
            ovf_q <= ovf_q || ovf_set; // [R13]
            bad_op_q <= bad_op_q || bad_op_set;
         end
      end
   end

   // write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         awready_q <= !aw_held_q && !(s_axi_awvalid && awready_q);
         wready_q <= !w_held_q && !(s_axi_wvalid && wready_q);
         if (s_axi_awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else if (arready_q && s_axi_arvalid) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0;
         if (s_axi_araddr == ADDR_STATUS) begin
            rdata_q[ST_COLLECT:ST_BUSY] <= {state_q == VCD_PARAM, xh_clip_vp_q, xh_on_q,
                                            bad_op_q, ovf_q, range_q, warn_q, !can_take};
         end else if (s_axi_araddr == ADDR_CMD) begin
            rdata_q <= {24'h0, opcode_q};
         end else if (s_axi_araddr == ADDR_VIEWPORT_X) begin
            rdata_q <= {viewport_q.x2, viewport_q.x1};
         end else if (s_axi_araddr == ADDR_VIEWPORT_Y) begin
            rdata_q <= {viewport_q.y2, viewport_q.y1};
         end else if (s_axi_araddr == ADDR_XH_SIZE) begin
            rdata_q <= {xh_size_y_q, xh_size_x_q};
         end else if (s_axi_araddr == ADDR_XH_POS) begin
            rdata_q <= {xh_pos_y_q, xh_pos_x_q};
         end else if (s_axi_araddr == ADDR_REF_X) begin
            rdata_q <= ref_q[0];
         end else if (s_axi_araddr == ADDR_REF_Y) begin
            rdata_q <= ref_q[1];
         end else if (s_axi_araddr == ADDR_REF_Z) begin
            rdata_q <= ref_q[2];
         end else if (s_axi_araddr == ADDR_WIN_X1) begin
            rdata_q <= win_q[0];
         end else if (s_axi_araddr == ADDR_WIN_X2) begin
            rdata_q <= win_q[1];
         end else if (s_axi_araddr == ADDR_WIN_Y1) begin
            rdata_q <= win_q[2];
         end else if (s_axi_araddr == ADDR_WIN_Y2) begin
            rdata_q <= win_q[3];
         end else if (s_axi_araddr == ADDR_ROT_XY) begin
            rdata_q <= {rot_q[1], rot_q[0]};
         end else if (s_axi_araddr == ADDR_ROT_Z) begin
            rdata_q <= {16'h0000, rot_q[2]};
         end else begin
            rresp_q <= RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

endmodule : vcd_decoder

//--- logic/vcd_pkg.sv
// Notes on behaviour
// [R1] viewport opcode B2, four unsigned coordinates
// [R2] integers are two bytes, low byte first
// [R3] always clip; reset viewport is whole screen
// [R4] viewport in pixels from bottom left
// [R5] unordered viewport pair warns and is swapped
// [R6] off-screen viewport coordinate raises a warning
// [R7] A3/A4/A5 rotate view x, y, z
// [R8] A1 sets three-real view reference point
// [R9] delay opcode 05 with unsigned frame count
// [R10] delay stalls commands for sixtieth-second frames
// [R11] window opcode B3 with four reals
// [R12] window maps onto most recent viewport
// [R13] window reports overflow or range error
// [R14] crosshair E2 flag 0/1/3, sizes 0..32767
// [R15] flag 1 clips screen, 3 clips viewport
// [R16] crosshair drawn complemented, centred on position
// [R17] flag zero disables crosshair, no sizes
// [R18] crosshair position E3, x 0..639, y 0..479
// [R19] crosshair parameter out of range is error
// [R20] collect exact parameter bytes, in order
package vcd_pkg;

   // opcodes
   localparam logic [7:0] OP_SET_VIEWPORT = 8'hB2;
   localparam logic [7:0] OP_SET_WINDOW = 8'hB3;
   localparam logic [7:0] OP_ROTATE_VIEW_X = 8'hA3;
   localparam logic [7:0] OP_ROTATE_VIEW_Y = 8'hA4;
   localparam logic [7:0] OP_ROTATE_VIEW_Z = 8'hA5;
   localparam logic [7:0] OP_VIEW_REF_POINT = 8'hA1;
   localparam logic [7:0] OP_DELAY = 8'h05;
   localparam logic [7:0] OP_CROSSHAIR_ENABLE = 8'hE2;
   localparam logic [7:0] OP_CROSSHAIR_POSITION = 8'hE3;

   // parameter byte counts
   localparam logic [4:0] LEN_VIEWPORT = 5'h08;
   localparam logic [4:0] LEN_WINDOW = 5'h10;
   localparam logic [4:0] LEN_ANGLE = 5'h02;
   localparam logic [4:0] LEN_REF_POINT = 5'h0C;
   localparam logic [4:0] LEN_DELAY = 5'h02;
   localparam logic [4:0] LEN_XH_FLAG = 5'h01;
   localparam logic [4:0] LEN_XH_FULL = 5'h05;
   localparam logic [4:0] LEN_XH_POS = 5'h04;

   // screen limits, crosshair size limit and crosshair flags
   localparam logic [15:0] SCREEN_X_MAX = 16'h027F;
   localparam logic [15:0] SCREEN_Y_MAX = 16'h01DF;
   localparam logic [15:0] XH_SIZE_MAX = 16'h7FFF;
   localparam logic [7:0] XH_FLAG_OFF = 8'h00;
   localparam logic [7:0] XH_FLAG_SCREEN = 8'h01;
   localparam logic [7:0] XH_FLAG_VIEWPORT = 8'h03;

   // frame timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int FRAME_PERIOD_NS = 16_666_667;
   localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;

   // register byte addresses
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_VIEWPORT_X = 8'h08;
   localparam logic [7:0] ADDR_VIEWPORT_Y = 8'h0C;
   localparam logic [7:0] ADDR_XH_SIZE = 8'h10;
   localparam logic [7:0] ADDR_XH_POS = 8'h14;
   localparam logic [7:0] ADDR_REF_X = 8'h18;
   localparam logic [7:0] ADDR_REF_Y = 8'h1C;
   localparam logic [7:0] ADDR_REF_Z = 8'h20;
   localparam logic [7:0] ADDR_WIN_X1 = 8'h24;
   localparam logic [7:0] ADDR_WIN_X2 = 8'h28;
   localparam logic [7:0] ADDR_WIN_Y1 = 8'h2C;
   localparam logic [7:0] ADDR_WIN_Y2 = 8'h30;
   localparam logic [7:0] ADDR_ROT_XY = 8'h34;
   localparam logic [7:0] ADDR_ROT_Z = 8'h38;

   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_WARN = 1;
   localparam int ST_RANGE = 2;
   localparam int ST_OVERFLOW = 3;
   localparam int ST_BAD_OP = 4;
   localparam int ST_CROSSHAIR_ENABLE_ON = 5;
   localparam int ST_CROSSHAIR_ENABLE_VP = 6;
   localparam int ST_COLLECT = 7;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      VCD_IDLE = 2'b00,
      VCD_PARAM = 2'b01,
      VCD_EXEC = 2'b11,
      VCD_DELAY = 2'b10
   } vcd_state_t;

   typedef struct packed {
      logic [15:0] x1;
      logic [15:0] x2;
      logic [15:0] y1;
      logic [15:0] y2;
   } vcd_viewport_t;

   localparam vcd_viewport_t VIEWPORT_RESET = '{16'h0000, 16'h027F, 16'h0000, 16'h01DF};

   typedef struct packed {
      logic valid;
      logic [1:0] axis;
      logic [15:0] angle;
   } vcd_rot_evt_t;

endpackage : vcd_pkg

//--- testbench/vcd_decoder_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module vcd_decoder_bench;
   import vcd_pkg::*;
   localparam int FC = 10;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int t0;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdt, d;
   logic [3:0] ws;
   logic [1:0] bre, rre, r;
   logic awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry;
   vcd_rot_evt_t rot_evt, last_rot;
   always #4 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   always @(posedge aclk) if (rot_evt.valid) last_rot <= rot_evt;
   vcd_decoder #(.FRAME_CYCLES_P(FC)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bre),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rre), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .rot_evt(rot_evt));
   vcd_host host (.aclk(aclk),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bre),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rre), .s_axi_rvalid(rv),
      .s_axi_rready(rry));
   // first byte sits in the top of the n-byte value
   task cmd(input logic [135:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         host.wr(ADDR_CMD, {24'h0, v[8*(n-1-i) +: 8]}, r);
      end
   endtask : cmd
   task chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      host.rd(a, d, r);
      `CHK(d & m, e)
   endtask : chk
   task clr;
      host.wr(ADDR_STATUS, 32'h1E, r);
   endtask : clr
   task fin(input string s);
      $display("test %s done", s);
   endtask : fin
   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #400000;
      errors++;
      wrap_up;
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      chk(ADDR_VIEWPORT_X, '1, 32'h27F0000);
      chk(ADDR_VIEWPORT_Y, '1, 32'h1DF0000);
      chk(ADDR_STATUS, '1, 32'h0);
      fin("reset");
      cmd(72'hB200002C0100006400, 9);
      chk(ADDR_VIEWPORT_X, '1, 32'h12C0000);
      chk(ADDR_VIEWPORT_Y, '1, 32'h640000);
      chk(ADDR_STATUS, 32'h2, 32'h0);
      cmd(24'hB22C01, 3);
      chk(ADDR_STATUS, 32'h80, 32'h80);
      cmd(48'h0A0005006400, 6);
      chk(ADDR_VIEWPORT_X, '1, 32'h12C000A);
      chk(ADDR_STATUS, 32'h82, 32'h2);
      clr;
      cmd(72'hB20000BC0200006400, 9);
      chk(ADDR_VIEWPORT_X, '1, 32'h2BC0000);
      chk(ADDR_STATUS, 32'h2, 32'h2);
      fin("viewport");
      for (int n = 0; n < 4; n += 3) begin
         cmd({8'h05, 8'(n), 8'h00}, 3);
         t0 = cyc;
         cmd(8'hFF, 1);
         `CHK(cyc - t0 >= n * FC - 2 && cyc - t0 <= n * FC + 8, 1'b1)
      end
      chk(ADDR_STATUS, 32'h11, 32'h10);
      fin("delay");
      for (int i = 0; i < 3; i++) begin
         cmd({8'(8'hA3 + i), 8'(8'h1D + i), 8'h00}, 3);
         repeat (4) @(posedge aclk);
         `CHK(last_rot, vcd_rot_evt_t'({1'b1, 2'(i), 16'(16'h001D + i)}))
      end
      chk(ADDR_ROT_XY, '1, 32'h1E001D);
      chk(ADDR_ROT_Z, '1, 32'h1F);
      cmd(104'hA164000000E7FF000032000000, 13);
      chk(ADDR_REF_X, '1, 32'h64);
      chk(ADDR_REF_Y, '1, 32'hFFE7);
      chk(ADDR_REF_Z, '1, 32'h32);
      fin("view");
      clr;
      cmd(136'hB3E7FF0000320000009600000064000000, 17);
      chk(ADDR_WIN_X1, '1, 32'hFFE7);
      chk(ADDR_WIN_Y2, '1, 32'h64);
      cmd(136'hB305000000050000000100000002000000, 17);
      chk(ADDR_STATUS, 32'hC, 32'h4);
      cmd(136'hB3FFFFFFFFFFFFFF7F0100000002000000, 17);
      chk(ADDR_STATUS, 32'h8, 32'h8);
      chk(ADDR_WIN_X1, '1, 32'hFFE7);
      fin("window");
      clr;
      cmd(40'hE305000500, 5);
      chk(ADDR_XH_POS, '1, 32'h50005);
      cmd(40'hE380020500, 5);
      chk(ADDR_XH_POS, '1, 32'h50005);
      chk(ADDR_STATUS, 32'h4, 32'h4);
      clr;
      cmd(48'hE20164006400, 6);
      chk(ADDR_STATUS, 32'h64, 32'h20);
      chk(ADDR_XH_SIZE, '1, 32'h640064);
      cmd(48'hE20310002000, 6);
      chk(ADDR_STATUS, 32'h60, 32'h60);
      cmd(16'hE200, 2);
      cmd(16'hE202, 2);
      chk(ADDR_STATUS, 32'hE4, 32'h44);
      clr;
      cmd(48'hE20100800000, 6);
      chk(ADDR_XH_SIZE, '1, 32'h200010);
      chk(ADDR_STATUS, 32'h4, 32'h4);
      fin("crosshair");
      host.rd(8'hFC, d, r);
      `CHK(r, RESP_SLVERR)
      host.wr(8'hFC, 32'h0, r);
      `CHK(r, RESP_SLVERR)
      fin("unmapped");
      wrap_up;
   end
endmodule : vcd_decoder_bench

//--- testbench/vcd_decoder_chk.sv
`timescale 1ns/1ps
module vcd_decoder_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire vcd_pkg::vcd_rot_evt_t rot_evt
);
   import vcd_pkg::*;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   chk_ar_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready while reading");
   chk_w_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready while responding");
   chk_b_after_take: assert property ($rose(s_axi_bvalid) |->
      $past(s_axi_awready) == 1'b0) else $error("response without write");
   chk_rot_pulse: assert property (rot_evt.valid |=> !rot_evt.valid)
      else $error("rotation pulse too long");
   chk_rot_axis: assert property (rot_evt.valid |-> rot_evt.axis != 2'h3)
      else $error("bad rotation axis");
   cover property (rot_evt.valid);
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule : vcd_decoder_chk

bind vcd_decoder vcd_decoder_chk u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .rot_evt(rot_evt));

//--- testbench/vcd_host.sv
`timescale 1ns/1ps
module vcd_host (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         // released address and data lines show the inverse, never stale data
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : rd
endmodule : vcd_host
